/* File: design/panel_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - both keys together toggle run and input or calibration mode
// - limit relays off in input and calibration modes
// - idle 1 min input or 2 min calibration returns to run
// - switches pick parameter input, cal resistor, range 0, cal ranges
// - current output follows conductance, clamped to zero (4 mA with live zero) and 20 mA
// - start above end value gives inverse current mapping
// - printer link runs at 2400 baud
// - frame: low start, eight data lsb first, high stop
// - print only when enabled and released by input or switch
// - print on four limit crossing events
// - crossing print holds label, date time, values, ident
// - minimum interval between prints, delay after limit crossed
// - three hourly timed prints, hour zero disables
// - manual print needs idle printer and contact held 1 s
// - up plus enter with unlock switch enters selection, relays drop
// - leave selection on second key pair or 60 s idle
// - short up press raises ident on release
// - up held over 1 s raises level instead
// - enter shows value; further enter back to selection
// - enter before up exits unchanged; up starts editing
// - edit from fourth digit, up wraps 9 to 0, enter next
// - after four digits enter returns, up restarts entry
module panel_ctrl #(
  parameter int unsigned SEC_CYCLES = panel_pkg::CLK_HZ,
  parameter int unsigned BIT_CYCLES = panel_pkg::BIT_CYCLES
) (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  key_up,
  input  wire logic                  key_enter,
  input  wire panel_pkg::switches_t  sw,
  input  wire logic                  print_release_switch,
  input  wire panel_pkg::print_cfg_t pcfg,
  input  wire logic                  live_zero,
  input  wire logic [15:0]           out_start,
  input  wire logic [15:0]           out_end,
  input  wire logic                  relay1_req,
  input  wire logic                  relay2_req,
  input  wire logic                  relay_t_req,
  output logic                       relay1,
  output logic                       relay2,
  output logic                       relay_t,
  output logic                       fault_relay,
  output logic [5:0]                 mode,
  output logic                       base_range_only,
  output logic                       cal_base_range,
  output logic                       cal_main_range,
  output logic                       mv_display_ok,
  output logic                       cal_resistor_on,
  output logic [2:0]                 param_level,
  output logic [3:0]                 param_ident,
  output logic [15:0]                edit_value,
  output logic [3:0]                 digit_blank_n,
  output logic                       param_write,
  output logic [15:0]                current_ua,
  output logic                       txd
);
  typedef struct packed {
    panel_pkg::mode_t mode;
    logic [1:0]  keys;
    logic [39:0] idle; // two idle minutes overflow 32 bits at full clock
    logic [31:0] up_hold;
    logic        up_long;
    logic [1:0]  digit;
    logic        editing;
    logic        done;
    logic [15:0] val;
    logic        wr;
    logic [1:0]  zone;
    logic [31:0] sec_cnt;
    logic [15:0] since_print;
    logic [15:0] delay_cnt;
    logic [7:0]  pend;
    logic [4:0]  last_hour;
    logic [31:0] man_cnt;
    logic [7:0]  job;
    logic [3:0]  chr;
    logic [15:0] cur;
    logic [2:0]  lvl;
    logic [3:0]  idn;
  } st_t;
  st_t s_reg, s_next;

  localparam logic [31:0] LONG_CYC = 32'(64'(panel_pkg::LONG_PRESS_MS) * SEC_CYCLES / 1000);
  localparam logic [31:0] MAN_CYC  = 32'(64'(panel_pkg::MANUAL_HOLD_MS) * SEC_CYCLES / 1000);
  localparam logic [39:0] IN_TMO   = 40'(panel_pkg::INPUT_TMO_S) * 40'(SEC_CYCLES);
  localparam logic [39:0] CAL_TMO  = 40'(panel_pkg::CAL_TMO_S) * 40'(SEC_CYCLES);
  localparam logic [39:0] PAR_TMO  = 40'(panel_pkg::PARAM_TMO_S) * 40'(SEC_CYCLES);

  logic        both_rise, up_rel, en_rise, any_rise, released, tx_ready, tx_valid;
  logic        busy, sec_tick;
  logic [7:0]  tx_data;
  logic [1:0]  zone_now;
  logic [31:0] span, off, scaled;

  assign both_rise = key_up && key_enter && !(s_reg.keys == 2'b11);
  assign up_rel    = !key_up && s_reg.keys[1] && !key_enter && !s_reg.keys[0];
  assign en_rise   = key_enter && !s_reg.keys[0] && !key_up;
  assign any_rise  = (key_up && !s_reg.keys[1]) || (key_enter && !s_reg.keys[0]);
  assign released  = pcfg.print_enable && (pcfg.print_release_input || print_release_switch);
  assign busy      = s_reg.job != 8'h00;
  assign sec_tick  = s_reg.sec_cnt == 32'(SEC_CYCLES - 1);
  assign zone_now  = (pcfg.cond > pcfg.lim2) ? 2'd2 : (pcfg.cond > pcfg.lim1) ? 2'd1 : 2'd0;

  // scaled current in microamps, inverse when start above end
  always_comb
  begin
    span   = 32'h0;
    off    = 32'h0;
    scaled = 32'h0;
    if (out_start <= out_end)
    begin
      span = {16'h0, out_end - out_start};
      off  = (pcfg.cond > out_start) ? {16'h0, pcfg.cond - out_start} : 32'h0;
    end
    else
    begin
      span = {16'h0, out_start - out_end};
      off  = (pcfg.cond < out_start) ? {16'h0, out_start - pcfg.cond} : 32'h0;
    end
    if (off > span)
      off = span;
    if (span != 32'h0)
      scaled = (off * (live_zero ? 32'd16000 : 32'd20000)) / span;
  end

  // printout: job code, date, hour, cond, temp, ident bytes
  always_comb
  begin
    unique case (s_reg.chr)
      4'h0:    tx_data = s_reg.job;
      4'h1:    tx_data = pcfg.clock_date[15:8];
      4'h2:    tx_data = pcfg.clock_date[7:0];
      4'h3:    tx_data = {3'h0, pcfg.clock_hour};
      4'h4:    tx_data = pcfg.cond[15:8];
      4'h5:    tx_data = pcfg.cond[7:0];
      4'h6:    tx_data = pcfg.temp[15:8];
      4'h7:    tx_data = pcfg.temp[7:0];
      4'h8:    tx_data = pcfg.ident[15:8];
      default: tx_data = pcfg.ident[7:0];
    endcase
  end
  assign tx_valid = busy;

  always_comb
  begin
    s_next      = s_reg;
    s_next.keys = {key_up, key_enter};
    s_next.wr   = 1'b0;
    s_next.idle = any_rise ? 40'h0 : s_reg.idle + 40'h1;
    s_next.up_hold = key_up ? s_reg.up_hold + 32'h1 : 32'h0;
    if (!key_up)
      s_next.up_long = 1'b0;
    unique case (s_reg.mode)
      panel_pkg::M_RUN:
        if (both_rise)
        begin
          s_next.idle = 40'h0;
          if (sw.param_unlock_switch)
            s_next.mode = panel_pkg::M_SELECT;
          else if (sw.main_range_cal_switch || sw.cal_resistor_switch)
            s_next.mode = panel_pkg::M_CAL;
          else
            s_next.mode = panel_pkg::M_INPUT;
        end
      panel_pkg::M_INPUT:
        if (both_rise || s_reg.idle >= IN_TMO)
          s_next.mode = panel_pkg::M_RUN;
      panel_pkg::M_CAL:
        if (both_rise || s_reg.idle >= CAL_TMO)
          s_next.mode = panel_pkg::M_RUN;
      default:
        if (both_rise || s_reg.idle >= PAR_TMO)
          s_next.mode = panel_pkg::M_RUN;
        else if (s_reg.mode == panel_pkg::M_SELECT)
        begin
          if (key_up && s_reg.up_hold == LONG_CYC)
          begin
            s_next.up_long = 1'b1;
            s_next.lvl = (s_reg.lvl == 3'(panel_pkg::LEVEL_MAX)) ? 3'h0 : s_reg.lvl + 3'h1;
            s_next.idn = 4'h1;
          end
          else if (up_rel && !s_reg.up_long)
            s_next.idn = s_reg.idn + 4'h1;
          else if (en_rise)
          begin
            s_next.mode = panel_pkg::M_SHOW;
            s_next.editing = 1'b0;
            s_next.done = 1'b0;
          end
        end
        else if (s_reg.mode == panel_pkg::M_SHOW)
        begin
          if (en_rise)
            s_next.mode = panel_pkg::M_SELECT;
          else if (up_rel)
          begin
            s_next.mode  = panel_pkg::M_EDIT;
            s_next.digit = 2'd3;
            s_next.val   = 16'h0;
            s_next.done  = 1'b0;
          end
        end
        else
        begin
          if (s_reg.done)
          begin
            if (en_rise)
            begin
              s_next.mode = panel_pkg::M_SELECT;
              s_next.wr   = 1'b1;
            end
            else if (up_rel)
            begin
              s_next.digit = 2'd3;
              s_next.val   = 16'h0;
              s_next.done  = 1'b0;
            end
          end
          else if (up_rel)
            s_next.val[4*(3-s_reg.digit) +: 4] =
              (s_reg.val[4*(3-s_reg.digit) +: 4] == 4'h9) ? 4'h0
              : s_reg.val[4*(3-s_reg.digit) +: 4] + 4'h1;
          else if (en_rise)
          begin
            if (s_reg.digit == 2'd0)
              s_next.done = 1'b1;
            else
              s_next.digit = s_reg.digit - 2'd1;
          end
        end
    endcase

    // printer scheduling
    s_next.sec_cnt = sec_tick ? 32'h0 : s_reg.sec_cnt + 32'h1;
    if (sec_tick && s_reg.since_print != 16'hffff)
      s_next.since_print = s_reg.since_print + 16'h1;
    s_next.zone = zone_now;
    if (zone_now != s_reg.zone)
    begin
      s_next.delay_cnt = 16'h0;
      if (zone_now > s_reg.zone)
        s_next.pend = (zone_now == 2'd2 && s_reg.zone == 2'd1) ? panel_pkg::JOB_ABOVE2
                      : (zone_now == 2'd2) ? panel_pkg::JOB_ABOVE2 : panel_pkg::JOB_ABOVE1;
      else
        s_next.pend = (zone_now == 2'd1) ? panel_pkg::JOB_BELOW2 : panel_pkg::JOB_BELOW1;
    end
    else if (sec_tick && s_reg.delay_cnt != 16'hffff)
      s_next.delay_cnt = s_reg.delay_cnt + 16'h1;
    if (pcfg.clock_hour != s_reg.last_hour)
    begin
      s_next.last_hour = pcfg.clock_hour;
      if (pcfg.clock_hour != 5'd0 && (pcfg.clock_hour == pcfg.hour_a ||
          pcfg.clock_hour == pcfg.hour_b || pcfg.clock_hour == pcfg.hour_c))
        if (s_next.pend == 8'h00)
          s_next.pend = panel_pkg::JOB_TIMED;
    end
    s_next.man_cnt = pcfg.print_release_input ? s_reg.man_cnt + 32'h1 : 32'h0;
    if (!busy && s_reg.pend == 8'h00 && tx_ready && released && s_reg.man_cnt == MAN_CYC)
      s_next.pend = panel_pkg::JOB_MANUAL;
    if (!released)
      s_next.pend = 8'h00;
    if (released && !busy && s_reg.pend != 8'h00 && s_reg.since_print >= pcfg.interval_s &&
        (s_reg.pend == panel_pkg::JOB_TIMED || s_reg.pend == panel_pkg::JOB_MANUAL ||
         s_reg.delay_cnt >= pcfg.delay_s))
    begin
      s_next.job = s_reg.pend;
      s_next.pend = 8'h00;
      s_next.chr = 4'h0;
      s_next.since_print = 16'h0;
    end
    else if (busy && tx_ready)
    begin
      s_next.chr = s_reg.chr + 4'h1;
      if (s_reg.chr == 4'h9)
        s_next.job = 8'h00;
    end

    // clamp between zero (4 mA with live zero) and full scale
    s_next.cur = 16'((live_zero ? 32'd4000 : 32'd0) + scaled);
    if (s_next.cur > 16'(panel_pkg::MA_FULL * 1000))
      s_next.cur = 16'(panel_pkg::MA_FULL * 1000);
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_reg      <= '0;
      s_reg.mode <= panel_pkg::M_RUN;
      s_reg.idn  <= 4'h1;
    end
    else
      s_reg <= s_next;
  end

  uart_tx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_tx (
    .clk_sys(clk_sys),
    .nrst   (nrst),
    .valid  (tx_valid),
    .data   (tx_data),
    .ready  (tx_ready),
    .txd    (txd)
  );

  assign relay1 = relay1_req && s_reg.mode == panel_pkg::M_RUN;
  assign relay2 = relay2_req && s_reg.mode == panel_pkg::M_RUN;
  assign relay_t = relay_t_req && s_reg.mode == panel_pkg::M_RUN;
  assign fault_relay = 1'b1;
  assign mode = s_reg.mode;
  assign base_range_only = sw.force_base_range_switch;
  assign cal_base_range = sw.force_base_range_switch && sw.main_range_cal_switch;
  assign cal_main_range = !sw.force_base_range_switch && sw.main_range_cal_switch;
  assign mv_display_ok = sw.main_range_cal_switch;
  assign cal_resistor_on = sw.cal_resistor_switch;
  assign param_level = s_reg.lvl;
  assign param_ident = s_reg.idn;
  assign edit_value = s_reg.val;
  assign digit_blank_n = s_reg.mode != panel_pkg::M_EDIT || s_reg.done ? 4'hf
                         : (4'hf >> s_reg.digit);
  assign param_write = s_reg.wr;
  assign current_ua = s_reg.cur;

  property p_relays_off;
    @(posedge clk_sys) disable iff (!nrst)
      (s_reg.mode != panel_pkg::M_RUN) |-> !relay1 && !relay2 && !relay_t;
  endproperty
  a_relays_off: assert property (p_relays_off) else $error("relay on outside run");

  property p_toggle;
    @(posedge clk_sys) disable iff (!nrst)
      (s_reg.mode == panel_pkg::M_RUN && both_rise) |=> s_reg.mode != panel_pkg::M_RUN;
  endproperty
  a_toggle: assert property (p_toggle) else $error("key pair did not leave run");

  property p_timeout;
    @(posedge clk_sys) disable iff (!nrst)
      (s_reg.mode == panel_pkg::M_INPUT && s_reg.idle >= IN_TMO && !both_rise)
      |=> s_reg.mode == panel_pkg::M_RUN;
  endproperty
  a_timeout: assert property (p_timeout) else $error("input timeout missed");

  property p_clamp;
    @(posedge clk_sys) disable iff (!nrst)
      live_zero |=> current_ua >= 16'd4000 || $past(!live_zero);
  endproperty
  a_clamp: assert property (p_clamp) else $error("current under live zero");

  property p_noprint;
    @(posedge clk_sys) disable iff (!nrst)
      (!busy && !released) |=> !busy;
  endproperty
  a_noprint: assert property (p_noprint) else $error("print without release");

  property p_wrap;
    @(posedge clk_sys) disable iff (!nrst)
      (s_reg.mode == panel_pkg::M_EDIT) |-> s_reg.val[15:12] <= 4'h9;
  endproperty
  a_wrap: assert property (p_wrap) else $error("digit above nine");

  property p_fault;
    @(posedge clk_sys) disable iff (!nrst)
      (s_reg.mode == panel_pkg::M_SELECT) |-> fault_relay;
  endproperty
  a_fault: assert property (p_fault) else $error("fault relay dropped");

  property p_par_exit;
    @(posedge clk_sys) disable iff (!nrst)
      (s_reg.mode == panel_pkg::M_SELECT && both_rise) |=> s_reg.mode == panel_pkg::M_RUN;
  endproperty
  a_par_exit: assert property (p_par_exit) else $error("selection not left");
endmodule

/* File: inc/panel_pkg.sv */
package panel_pkg;
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned BAUD           = 2400;
  localparam int unsigned BIT_CYCLES     = CLK_HZ / BAUD;
  localparam int unsigned INPUT_TMO_S    = 60;
  localparam int unsigned CAL_TMO_S      = 120;
  localparam int unsigned PARAM_TMO_S    = 60;
  localparam int unsigned LONG_PRESS_MS  = 1000;
  localparam int unsigned MANUAL_HOLD_MS = 1000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned MA_ZERO_LIVE   = 4;
  localparam int unsigned MA_FULL        = 20;
  localparam logic [7:0]  JOB_ABOVE1     = 8'h01;
  localparam logic [7:0]  JOB_ABOVE2     = 8'h02;
  localparam logic [7:0]  JOB_BELOW2     = 8'h03;
  localparam logic [7:0]  JOB_BELOW1     = 8'h04;
  localparam logic [7:0]  JOB_TIMED      = 8'h05;
  localparam logic [7:0]  JOB_MANUAL     = 8'h06;
  localparam int unsigned LEVEL_MAX      = 7;

  typedef enum logic [5:0] {
    M_RUN    = 6'b000001,
    M_INPUT  = 6'b000010,
    M_CAL    = 6'b000100,
    M_SELECT = 6'b001000,
    M_SHOW   = 6'b010000,
    M_EDIT   = 6'b100000
  } mode_t;

  typedef struct packed {
    logic       param_unlock_switch;
    logic       cal_resistor_switch;
    logic       force_base_range_switch;
    logic       main_range_cal_switch;
  } switches_t;

  typedef struct packed {
    logic       print_enable;
    logic       print_release_input;
    logic [15:0] ident;
    logic [15:0] cond;
    logic [15:0] temp;
    logic [15:0] lim1;
    logic [15:0] lim2;
    logic [15:0] interval_s;
    logic [15:0] delay_s;
    logic [4:0]  hour_a;
    logic [4:0]  hour_b;
    logic [4:0]  hour_c;
    logic [4:0]  clock_hour;
    logic [15:0] clock_date;
  } print_cfg_t;
endpackage

/* File: design/uart_tx.sv */
`timescale 1ns/1ps
module uart_tx #(
  parameter int unsigned BIT_CYCLES = panel_pkg::BIT_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       valid,
  input  wire logic [7:0] data,
  output logic            ready,
  output logic            txd
);
  typedef struct packed {
    logic        busy;
    logic [3:0]  bitn;
    logic [9:0]  shift;
    logic [31:0] cnt;
  } tx_t;
  tx_t st_reg, st_next;

  always_comb
  begin
    st_next = st_reg;
    if (!st_reg.busy)
    begin
      if (valid)
      begin
        // stop, data lsb first, start
        st_next.shift = {1'b1, data, 1'b0};
        st_next.busy  = 1'b1;
        st_next.bitn  = 4'h0;
        st_next.cnt   = 32'h0;
      end
    end
    // full width: a bit at the system clock spans more than 16 bits of cycles
    else if (st_reg.cnt == 32'(BIT_CYCLES - 1))
    begin
      st_next.cnt   = 32'h0;
      st_next.shift = {1'b1, st_reg.shift[9:1]};
      st_next.bitn  = st_reg.bitn + 4'h1;
      if (st_reg.bitn == 4'h9)
        st_next.busy = 1'b0;
    end
    else
      st_next.cnt = st_reg.cnt + 32'h1;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      st_reg <= '{busy: 1'b0, bitn: 4'h0, shift: 10'h3ff, cnt: 32'h0};
    else
      st_reg <= st_next;
  end

  assign ready = !st_reg.busy;
  assign txd   = st_reg.busy ? st_reg.shift[0] : 1'b1;

  property p_frame_len;
    @(posedge clk_sys) disable iff (!nrst)
      (valid && ready) |=> !ready [*8];
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame ended early");

  property p_start_low;
    @(posedge clk_sys) disable iff (!nrst)
      (valid && ready) |=> !txd;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
endmodule

/* File: tb/printer_model.sv */
`timescale 1ns/1ps
module printer_model #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input  wire logic  clk_sys,
  input  wire logic  rxd,
  output logic [7:0] rx_count,
  output logic [7:0] rx_byte,
  output logic       frame_err
);
  // sampled mid-bit, so a rate error shows up as a corrupt byte
  initial
  begin
    rx_count = 8'h00;
    rx_byte = 8'h00;
    frame_err = 1'b0;
    forever
    begin
      @(negedge rxd);
      repeat (BIT_CYCLES / 2) @(posedge clk_sys);
      if (rxd !== 1'b0)
        frame_err = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES) @(posedge clk_sys);
        rx_byte[i] = rxd;
      end
      repeat (BIT_CYCLES) @(posedge clk_sys);
      if (rxd !== 1'b1)
        frame_err = 1'b1;
      rx_count = rx_count + 8'h01;
    end
  end
endmodule

/* File: tb/panel_ctrl_test.sv */
`timescale 1ns/1ps
module panel_ctrl_test;
  localparam int unsigned SEC = 200;
  localparam int unsigned UBIT = 16;
  typedef struct packed {
    logic [3:0]  s;
    logic [2:0]  rq;
    logic        lz;
    logic [15:0] st;
    logic [15:0] en;
    logic [15:0] c;
    logic [4:0]  ex;
    logic [4:0]  mk;
    logic [15:0] cur;
  } row_t;
  // ex: range 0 only, cal range 0, cal main, mV ok, cal resistor; mk hides unclear bits
  row_t rows [6] = '{
    '{4'h0, 3'h7, 1'b1, 16'h0064, 16'h00c8, 16'h0032, 5'h00, 5'h1f, 16'h0fa0},
    '{4'h4, 3'h5, 1'b1, 16'h0064, 16'h00c8, 16'h012c, 5'h01, 5'h1f, 16'h4e20},
    '{4'h2, 3'h2, 1'b0, 16'h0000, 16'h00c8, 16'h0064, 5'h10, 5'h1f, 16'h2710},
    '{4'h3, 3'h0, 1'b1, 16'h00c8, 16'h0064, 16'h012c, 5'h18, 5'h1d, 16'h0fa0},
    '{4'h1, 3'h1, 1'b1, 16'h00c8, 16'h0064, 16'h0032, 5'h06, 5'h1f, 16'h4e20},
    '{4'h8, 3'h6, 1'b1, 16'h0000, 16'h00c8, 16'h0064, 5'h00, 5'h1f, 16'h2ee0}
  };
  logic                  clk_sys = 1'b0;
  logic                  nrst = 1'b0;
  logic                  key_up = 1'b0;
  logic                  key_enter = 1'b0;
  panel_pkg::switches_t  sw = '0;
  logic                  print_release_switch = 1'b0;
  panel_pkg::print_cfg_t pcfg = '0;
  logic                  live_zero = 1'b0;
  logic [15:0]           out_start = 16'h0000;
  logic [15:0]           out_end = 16'h0000;
  logic                  relay1_req = 1'b0;
  logic                  relay2_req = 1'b0;
  logic                  relay_t_req = 1'b0;
  logic                  relay1, relay2, relay_t, fault_relay, param_write, txd;
  logic                  base_range_only, cal_base_range, cal_main_range;
  logic                  mv_display_ok, cal_resistor_on, frame_err;
  logic [5:0]            mode;
  logic [2:0]            param_level, relays, lv;
  logic [3:0]            param_ident, digit_blank_n, d;
  logic [4:0]            so;
  logic [15:0]           edit_value, current_ua;
  logic [7:0]            rx_count, rx_byte;
  logic                  tx_low = 1'b0;
  int                    pw_cnt = 0;
  int                    failures = 0;
  int                    checks_done = 0;
  int                    n;
  assign relays = {relay1, relay2, relay_t};
  assign so = {base_range_only, cal_base_range, cal_main_range, mv_display_ok, cal_resistor_on};

  // short bit time so whole printouts fit in the run
  panel_ctrl #(
    .SEC_CYCLES(SEC),
    .BIT_CYCLES(UBIT)
  ) i_dut (
    .clk_sys, .nrst, .key_up, .key_enter, .sw, .print_release_switch, .pcfg, .live_zero,
    .out_start, .out_end, .relay1_req, .relay2_req, .relay_t_req, .relay1, .relay2, .relay_t,
    .fault_relay, .mode, .base_range_only, .cal_base_range, .cal_main_range, .mv_display_ok,
    .cal_resistor_on, .param_level, .param_ident, .edit_value, .digit_blank_n, .param_write,
    .current_ua, .txd
  );
  printer_model #(
    .BIT_CYCLES(UBIT)
  ) i_prn (
    .clk_sys, .rxd(txd), .rx_count, .rx_byte, .frame_err
  );

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (param_write === 1'b1)
      pw_cnt++;
    if (txd === 1'b0)
      tx_low = 1'b1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic press(input logic u, input logic e, input int hold);
    key_up = u;
    key_enter = e;
    step(hold);
    key_up = 1'b0;
    key_enter = 1'b0;
    step(4);
  endtask
  task automatic reset_dut();
    nrst = 1'b0;
    step(8);
    check(mode, panel_pkg::M_RUN);
    check(txd, 1'b1);
    check(current_ua, 16'h0000);
    check(param_ident, 4'h1);
    nrst = 1'b1;
    step(2);
  endtask
  initial
  begin
    #450us;
    failures++;
    results();
  end

  initial
  begin
    reset_dut();
    foreach (rows[i])
    begin
      sw = rows[i].s;
      {relay1_req, relay2_req, relay_t_req} = rows[i].rq;
      live_zero = rows[i].lz;
      out_start = rows[i].st;
      out_end = rows[i].en;
      pcfg.cond = rows[i].c;
      step(4);
      check(relays, rows[i].rq);
      check(so & rows[i].mk, rows[i].ex & rows[i].mk);
      check(current_ua, rows[i].cur);
    end
    $display("row tests done");
    sw = '0;
    press(1'b1, 1'b1, 3);
    check(mode, panel_pkg::M_INPUT);
    check(relays, 3'h0);
    step(60 * SEC - 20);
    check(mode, panel_pkg::M_INPUT);
    press(1'b1, 1'b0, 3);
    step(60 * SEC - 20);
    check(mode, panel_pkg::M_INPUT);
    step(40);
    check(mode, panel_pkg::M_RUN);
    sw.cal_resistor_switch = 1'b1;
    press(1'b1, 1'b1, 3);
    check(mode, panel_pkg::M_CAL);
    check(relays, 3'h0);
    step(120 * SEC - 20);
    check(mode, panel_pkg::M_CAL);
    step(40);
    check(mode, panel_pkg::M_RUN);
    press(1'b1, 1'b1, 3);
    press(1'b1, 1'b1, 3);
    check(mode, panel_pkg::M_RUN);
    $display("mode tests done");
    sw = 4'h8;
    press(1'b1, 1'b1, 3);
    check(mode, panel_pkg::M_SELECT);
    check(relays, 3'h0);
    check(fault_relay, 1'b1);
    key_up = 1'b1;
    step(5);
    check(param_ident, 4'h1);
    key_up = 1'b0;
    step(4);
    check(param_ident, 4'h2);
    lv = param_level;
    key_up = 1'b1;
    step(SEC + 50);
    key_up = 1'b0;
    step(4);
    check(param_level, lv + 3'h1);
    press(1'b0, 1'b1, 3);
    check(mode, panel_pkg::M_SHOW);
    press(1'b0, 1'b1, 3);
    check(mode, panel_pkg::M_SELECT);
    check(pw_cnt, 0);
    press(1'b0, 1'b1, 3);
    press(1'b1, 1'b0, 3);
    check(mode, panel_pkg::M_EDIT);
    check(digit_blank_n, 4'h1);
    d = edit_value[3:0];
    for (n = 1; n <= 10; n++)
    begin
      press(1'b1, 1'b0, 3);
      if (n == 1)
        check(edit_value[3:0], d == 4'h9 ? 4'h0 : d + 4'h1);
    end
    check(edit_value[3:0], d);
    repeat (4) press(1'b0, 1'b1, 3);
    check(digit_blank_n, 4'hf);
    press(1'b0, 1'b1, 3);
    check(mode, panel_pkg::M_SELECT);
    check(pw_cnt, 1);
    press(1'b1, 1'b1, 3);
    check(mode, panel_pkg::M_RUN);
    press(1'b1, 1'b1, 3);
    step(60 * SEC - 20);
    check(mode, panel_pkg::M_SELECT);
    step(40);
    check(mode, panel_pkg::M_RUN);
    $display("parameter tests done");
    pcfg.cond = 16'h0000;
    pcfg.lim1 = 16'h0064;
    pcfg.lim2 = 16'h00c8;
    pcfg.ident = 16'h3ca5;
    reset_dut();
    pcfg.print_release_input = 1'b1;
    tx_low = 1'b0;
    step(2 * SEC);
    check(tx_low, 1'b0);
    pcfg.print_enable = 1'b1;
    pcfg.print_release_input = 1'b0;
    step(2);
    pcfg.print_release_input = 1'b1;
    step(SEC - 20);
    check(tx_low, 1'b0);
    step(60);
    check(tx_low, 1'b1);
    // first frame done, second not yet sampled
    step(130);
    check(rx_count, 8'h01);
    check(rx_byte, panel_pkg::JOB_MANUAL);
    step(1500);
    check(rx_count, 8'h0a);
    check(rx_byte, 8'ha5);
    check(frame_err, 1'b0);
    pcfg.print_release_input = 1'b0;
    print_release_switch = 1'b1;
    pcfg.clock_hour = 5'h04;
    pcfg.hour_a = 5'h05;
    reset_dut();
    tx_low = 1'b0;
    step(50);
    check(tx_low, 1'b0);
    pcfg.clock_hour = 5'h05;
    step(50);
    check(tx_low, 1'b1);
    step(120);
    check(rx_count, 8'h0b);
    check(rx_byte, panel_pkg::JOB_TIMED);
    pcfg.hour_a = 5'h00;
    pcfg.delay_s = 16'h0001;
    reset_dut();
    tx_low = 1'b0;
    pcfg.cond = 16'h0096;
    step(SEC - 20);
    check(tx_low, 1'b0);
    step(100);
    check(tx_low, 1'b1);
    reset_dut();
    $display("print tests done");
    results();
  end
endmodule
